// ---- hdl/tca_pkg.sv ----
// constants of the temperature conversion and alert controller
// assumes a 10 MHz system clock and a byte-addressed register bus
package tca_pkg;
   localparam int CLK_HZ = 10_000_000;
   localparam int INTERVAL_MS = 800;
   localparam int INTERVAL_CYC = INTERVAL_MS * (CLK_HZ / 1000);
   localparam int WAKE_NS = 4000;
   localparam int WAKE_CYC = (WAKE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int CONV_NS = 25000;
   localparam int CONV_CYC = (CONV_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int INTERVAL_W = 23;
   localparam int PHASE_W = 9;
   // pointer codes of the data registers
   localparam logic [1:0] IDX_TEMP = 2'h0;
   localparam logic [1:0] IDX_CFG = 2'h1;
   localparam logic [1:0] IDX_THIGH = 2'h2;
   localparam logic [1:0] IDX_TLOW = 2'h3;
   // word indices of the bus map
   localparam logic [2:0] WORD_PTR = 3'h4;
   localparam logic [2:0] WORD_WIN = 3'h5;
   // configuration fields
   localparam int CFG_PD = 7;
   localparam int CFG_FLT = 6;
   localparam int CFG_ALDIS = 5;
   localparam int CFG_POL = 4;
   localparam int CFG_ARST = 3;
   localparam int CFG_ONESHOT = 2;
   localparam logic [7:0] CFG_RESET = 8'h40;
   localparam logic [7:0] CFG_FULL_MASK = 8'hF3;
   localparam logic [7:0] CFG_RED_MASK = 8'hC3;
   localparam logic [7:0] THIGH_RESET = 8'h7F;
   localparam logic [7:0] TLOW_RESET = 8'h80;
   localparam logic [9:0] TEMP_RESET = 10'h000;
   typedef enum logic [1:0] {TCA_SLEEP, TCA_WAKE, TCA_CONV} tca_state_t;
endpackage

// ---- hdl/tca_meas_if.sv ----
// result and limit signals between sequencer and indicator logic
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface tca_meas_if;
   logic [9:0] result;
   logic done;
   logic [7:0] thigh;
   logic [7:0] tlow;
   logic enable;
   logic clear;
   logic active;
   modport seq (output result, done, thigh, tlow, enable, clear, input active);
   modport alert (input result, done, thigh, tlow, enable, clear, output active);
endinterface

// ---- hdl/tca_timer.sv ----
// loadable down counter with a one-cycle expiry pulse
// assumes synchronous active-low reset
`timescale 1ns/1ps
module tca_timer #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [W-1:0] value,
   output logic done
);
   logic [W-1:0] count;
   assign done = count == W'(1);
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count <= '0;
      end else if (load) begin
         count <= value;
      end else if (count != '0) begin
         count <= count - W'(1);
      end
   end
endmodule

// ---- hdl/tca_alert.sv ----
// over-temperature compare and latched indicator state
// assumes done pulses once per finished conversion
`timescale 1ns/1ps
module tca_alert (
   input wire logic clk,
   input wire logic rst_n,
   tca_meas_if.alert m
);
   wire signed [7:0] top8 = $signed(m.result[9:2]);
   wire over = top8 > $signed(m.thigh);
   wire under = top8 < $signed(m.tlow);
   wire set_ev = m.done && over && m.enable;
   wire clr_ev = m.clear || (m.done && under);
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         m.active <= 1'b0;
      end else if (set_ev) begin
         m.active <= 1'b1;
      end else if (clr_ev) begin
         m.active <= 1'b0;
      end
   end
endmodule

// ---- hdl/tca_top.sv ----
// temperature conversion sequencer, limit registers and bus slave
// assumes an avalon-mm master with byte addresses, adc code valid at conversion end
//
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module tca_top #(
   parameter bit FULL_VARIANT = 1'b1,
   parameter int INTERVAL_CYCLES = tca_pkg::INTERVAL_CYC
) (
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   input wire logic [4:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic [9:0] ADC_CODE,
   output logic ANALOG_POWER,
   output logic ADC_HOLD,
   output logic LINE_FILTER_EN,
   output logic ALERT_O,
   output logic ALERT_OE_N
);
   tca_meas_if meas ();

   // bus slave state
   logic waitreq;
   logic [31:0] rdata;

   // register file
   logic [1:0] pointer;
   logic [7:0] cfg;
   logic [7:0] thigh;
   logic [7:0] tlow;
   logic [9:0] temp;

   // sequencer
   tca_pkg::tca_state_t state;
   tca_pkg::tca_state_t next_state;
   logic oneshot_pend;
   logic done_pulse;
   logic hold_pulse;
   logic alert_pin;
   logic alert_oe_n;
   logic power;

   // bus decode
   wire req = AVS_READ || AVS_WRITE;
   wire accept = req && !waitreq;
   wire [2:0] word = AVS_ADDRESS[4:2];
   wire lane0 = AVS_BYTEENABLE[0];
   wire [7:0] wbyte = AVS_WRITEDATA[7:0];
   wire is_ptr = word == tca_pkg::WORD_PTR;
   wire is_win = word == tca_pkg::WORD_WIN;
   wire is_data = word[2] == 1'b0;
   wire mapped = is_ptr || is_win || is_data;
   // direct data word or pointer-selected window
   wire [1:0] sel = is_win ? pointer : word[1:0];
   wire do_write = accept && AVS_WRITE && lane0;
   wire wr_ptr = do_write && is_ptr;
   wire wr_data = do_write && (is_win || is_data);
   wire wr_cfg = wr_data && sel == tca_pkg::IDX_CFG;
   wire wr_thigh = wr_data && sel == tca_pkg::IDX_THIGH && FULL_VARIANT;
   wire wr_tlow = wr_data && sel == tca_pkg::IDX_TLOW && FULL_VARIANT;
   wire [7:0] cfg_mask = FULL_VARIANT ? tca_pkg::CFG_FULL_MASK
                                      : tca_pkg::CFG_RED_MASK;
   wire oneshot_wr = wr_cfg && wbyte[tca_pkg::CFG_ONESHOT];
   wire arst_wr = wr_cfg && wbyte[tca_pkg::CFG_ARST] && FULL_VARIANT;

   // read mux
   logic [7:0] sel_data;
   always_comb begin
      case (sel)
         tca_pkg::IDX_TEMP: sel_data = 8'h00;
         tca_pkg::IDX_CFG: sel_data = cfg & cfg_mask;
         tca_pkg::IDX_THIGH: sel_data = FULL_VARIANT ? thigh : 8'h00;
         tca_pkg::IDX_TLOW: sel_data = FULL_VARIANT ? tlow : 8'h00;
         default: sel_data = 8'h00;
      endcase
   end
   wire [31:0] temp_word = {22'h00_0000, temp};
   wire [31:0] sel_word = (sel == tca_pkg::IDX_TEMP) ? temp_word
                                                      : {24'h00_0000, sel_data};
   wire [31:0] ptr_word = {30'h0000_0000, pointer};
   wire [31:0] next_rdata = !mapped ? 32'h0000_0000
                          : is_ptr ? ptr_word : sel_word;

   // bus handshake: one wait cycle, then the transfer completes
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         waitreq <= 1'b1;
      end else if (req && waitreq) begin
         waitreq <= 1'b0;
      end else begin
         waitreq <= 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         rdata <= 32'h0000_0000;
      end else if (AVS_READ && waitreq) begin
         rdata <= next_rdata;
      end
   end

   // pointer keeps only the select bits
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         pointer <= tca_pkg::IDX_TEMP;
      end else if (wr_ptr) begin
         pointer <= wbyte[1:0];
      end
   end

   // configuration: action bits are never stored
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         cfg <= tca_pkg::CFG_RESET;
      end else if (wr_cfg) begin
         cfg <= wbyte & cfg_mask;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         thigh <= tca_pkg::THIGH_RESET;
         tlow <= tca_pkg::TLOW_RESET;
      end else begin
         if (wr_thigh) begin
            thigh <= wbyte;
         end
         if (wr_tlow) begin
            tlow <= wbyte;
         end
      end
   end

   // configuration fields
   wire pd = cfg[tca_pkg::CFG_PD];
   wire filter_on = cfg[tca_pkg::CFG_FLT];
   wire alert_en = !cfg[tca_pkg::CFG_ALDIS] && FULL_VARIANT;
   wire alert_pol = cfg[tca_pkg::CFG_POL];

   // interval timebase, held reloaded in power-down
   // empty after reset, so the first cycle loads it
   logic tick;
   logic armed;
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         armed <= 1'b0;
      end else begin
         armed <= 1'b1;
      end
   end
   wire interval_load = pd || tick || !armed;
   tca_timer #(
      .W(tca_pkg::INTERVAL_W)
   ) u_interval (
      .clk(CLK_SYS),
      .rst_n(RESET_N),
      .load(interval_load),
      .value(tca_pkg::INTERVAL_W'(INTERVAL_CYCLES)),
      .done(tick)
   );

   // power-up and conversion phase timer
   logic phase_done;
   logic phase_load;
   logic [tca_pkg::PHASE_W-1:0] phase_value;
   tca_timer #(
      .W(tca_pkg::PHASE_W)
   ) u_phase (
      .clk(CLK_SYS),
      .rst_n(RESET_N),
      .load(phase_load),
      .value(phase_value),
      .done(phase_done)
   );

   // start conditions
   wire auto_start = tick && !pd;
   wire start = state == tca_pkg::TCA_SLEEP && (oneshot_pend || auto_start);

   // one-shot request waits for the end of the write, set beats clear
   wire next_pend = oneshot_wr || (oneshot_pend && !start);
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         oneshot_pend <= 1'b0;
      end else begin
         oneshot_pend <= next_pend;
      end
   end

   // sequencer next state
   always_comb begin
      next_state = state;
      phase_load = 1'b0;
      phase_value = '0;
      case (state)
         tca_pkg::TCA_SLEEP: begin
            if (start) begin
               next_state = tca_pkg::TCA_WAKE;
               phase_load = 1'b1;
               phase_value = tca_pkg::PHASE_W'(tca_pkg::WAKE_CYC);
            end
         end
         tca_pkg::TCA_WAKE: begin
            if (phase_done) begin
               next_state = tca_pkg::TCA_CONV;
               phase_load = 1'b1;
               phase_value = tca_pkg::PHASE_W'(tca_pkg::CONV_CYC);
            end
         end
         tca_pkg::TCA_CONV: begin
            if (phase_done) begin
               next_state = tca_pkg::TCA_SLEEP;
            end
         end
         default: begin
            next_state = tca_pkg::TCA_SLEEP;
         end
      endcase
   end

   wire conv_end = state == tca_pkg::TCA_CONV && phase_done;
   wire hold_now = state == tca_pkg::TCA_WAKE && phase_done;

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         state <= tca_pkg::TCA_SLEEP;
         power <= 1'b0;
         hold_pulse <= 1'b0;
         done_pulse <= 1'b0;
      end else begin
         state <= next_state;
         power <= next_state != tca_pkg::TCA_SLEEP;
         hold_pulse <= hold_now;
         done_pulse <= conv_end;
      end
   end

   // result register, one lsb is a quarter degree
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         temp <= tca_pkg::TEMP_RESET;
      end else if (conv_end) begin
         temp <= ADC_CODE;
      end
   end

   // indicator logic, full variant only
   assign meas.result = temp;
   assign meas.done = done_pulse;
   assign meas.thigh = thigh;
   assign meas.tlow = tlow;
   assign meas.enable = alert_en;
   assign meas.clear = arst_wr;

   generate
      if (FULL_VARIANT) begin : g_alert
         tca_alert u_alert (
            .clk(CLK_SYS),
            .rst_n(RESET_N),
            .m(meas)
         );
      end else begin : g_no_alert
         assign meas.active = 1'b0;
      end
   endgenerate

   // open-drain pin: pulled low when the level is low
   wire asserted = meas.active && alert_en;
   wire next_level = alert_pol ? asserted : !asserted;
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         alert_pin <= 1'b0;
         alert_oe_n <= 1'b1;
      end else begin
         alert_pin <= 1'b0;
         alert_oe_n <= !(FULL_VARIANT && !next_level);
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         LINE_FILTER_EN <= 1'b1;
      end else begin
         LINE_FILTER_EN <= filter_on;
      end
   end

   assign AVS_READDATA = rdata;
   assign AVS_WAITREQUEST = waitreq;
   assign ANALOG_POWER = power;
   assign ADC_HOLD = hold_pulse;
   assign ALERT_O = alert_pin;
   assign ALERT_OE_N = alert_oe_n;
endmodule

// ---- testbench/tca_top_asserts.sv ----
// port checker of the temperature controller
// assumes a bind onto tca_top and one clock domain
`timescale 1ns/1ps
module tca_top_asserts #(
   parameter int INTERVAL_CYCLES = 500
) (
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   input wire logic [4:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   input wire logic ANALOG_POWER,
   input wire logic ADC_HOLD,
   input wire logic LINE_FILTER_EN,
   input wire logic ALERT_O,
   input wire logic ALERT_OE_N
);
   logic pwr_q;
   logic [31:0] cnt;
   wire wr_ok = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
   wire rd_ok = AVS_READ && !AVS_WAITREQUEST;
   wire cfg_wr = wr_ok && AVS_ADDRESS == 5'h04;
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESET_N);
   // cycles since power last changed
   always_ff @(posedge CLK_SYS) begin
      pwr_q <= ANALOG_POWER;
      cnt <= (ANALOG_POWER != pwr_q) ? 32'h0 : cnt + 32'h1;
   end
   wait_one_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
      |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST) else $error("bus answer not one cycle");
   wake_hold_a: assert property ($rose(ANALOG_POWER) |-> ##[38:42] ADC_HOLD)
      else $error("hold not after power-up delay");
   conv_time_a: assert property ($fell(ANALOG_POWER) |-> cnt inside {[280:300]})
      else $error("conversion length wrong");
   hold_pulse_a: assert property (ADC_HOLD |-> ANALOG_POWER ##1 !ADC_HOLD)
      else $error("hold pulse wrong");
   shot_start_a: assert property (cfg_wr && AVS_WRITEDATA[2] && !ANALOG_POWER
      |-> ##[1:4] $rose(ANALOG_POWER)) else $error("one-shot did not start");
   filter_cfg_a: assert property (cfg_wr
      |-> ##2 LINE_FILTER_EN == $past(AVS_WRITEDATA[6], 2)) else $error("filter bit");
   open_drain_a: assert property (!ALERT_O) else $error("alert data not low");
   cfg_read_a: assert property (rd_ok && AVS_ADDRESS == 5'h04
      |-> AVS_READDATA[31:8] == 24'h0 && AVS_READDATA[3:2] == 2'h0) else $error("cfg read");
   temp_read_a: assert property (rd_ok && AVS_ADDRESS == 5'h00
      |-> AVS_READDATA[31:10] == 22'h0) else $error("temperature width");
   ptr_read_a: assert property (rd_ok && AVS_ADDRESS == 5'h10
      |-> AVS_READDATA[31:2] == 30'h0) else $error("pointer width");
   cover property ($rose(ANALOG_POWER) && cnt < INTERVAL_CYCLES);
   cover property (ADC_HOLD);
   cover property ($fell(ALERT_OE_N));
endmodule
bind tca_top tca_top_asserts #(.INTERVAL_CYCLES(INTERVAL_CYCLES)) u_chk (
   .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS),
   .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
   .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
   .AVS_WAITREQUEST(AVS_WAITREQUEST), .ANALOG_POWER(ANALOG_POWER), .ADC_HOLD(ADC_HOLD),
   .LINE_FILTER_EN(LINE_FILTER_EN), .ALERT_O(ALERT_O), .ALERT_OE_N(ALERT_OE_N)
);

// ---- testbench/tca_host.sv ----
// host model: register bus master of the controller
// assumes the same clock as the device
`timescale 1ns/1ps
module tca_host (
   input wire logic clk,
   output logic [4:0] address,
   output logic read,
   output logic write,
   output logic [31:0] writedata,
   output logic [3:0] byteenable,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   output logic timed_out
);
   initial begin
      address = 5'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0000_0000;
      byteenable = 4'hF;
      timed_out = 1'b0;
   end
   // one access, held until waitrequest seen low
   task automatic xfer(input logic rd, input logic [4:0] a, input logic [31:0] d,
         output logic [31:0] q);
      int n;
      @(posedge clk);
      address <= a;
      read <= rd;
      write <= !rd;
      writedata <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      q = readdata;
      if (waitrequest !== 1'b0) timed_out = 1'b1;
      read <= 1'b0;
      write <= 1'b0;
   endtask
endmodule

// ---- testbench/tb.sv ----
// self-checking bench of the temperature controller
// assumes the host model drives the bus; converter code comes from here
`timescale 1ns/1ps
module tb;
   localparam int IVL = 500;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [9:0] code = 10'h000;
   logic [4:0] a;
   logic r, w, wq, pwr, hold, filt, ao, aoen, to;
   logic [31:0] d, q, v;
   logic [3:0] be;
   logic [7:0] cfg;
   logic [31:0] q2;
   logic aoen2;
   int n_fail = 0;
   int total_checks = 0;
   int n, gap;
   always #50 clk = ~clk;
   tca_top #(.INTERVAL_CYCLES(IVL)) dut (.CLK_SYS(clk), .RESET_N(rst_n), .AVS_ADDRESS(a),
      .AVS_READ(r), .AVS_WRITE(w), .AVS_WRITEDATA(d), .AVS_BYTEENABLE(be),
      .AVS_READDATA(q), .AVS_WAITREQUEST(wq), .ADC_CODE(code), .ANALOG_POWER(pwr),
      .ADC_HOLD(hold), .LINE_FILTER_EN(filt), .ALERT_O(ao), .ALERT_OE_N(aoen));
   // reduced variant on the same bus and converter code
   tca_top #(.FULL_VARIANT(1'b0), .INTERVAL_CYCLES(IVL)) dut_red (.CLK_SYS(clk),
      .RESET_N(rst_n), .AVS_ADDRESS(a), .AVS_READ(r), .AVS_WRITE(w), .AVS_WRITEDATA(d),
      .AVS_BYTEENABLE(be), .AVS_READDATA(q2), .AVS_WAITREQUEST(), .ADC_CODE(code),
      .ANALOG_POWER(), .ADC_HOLD(), .LINE_FILTER_EN(), .ALERT_O(), .ALERT_OE_N(aoen2));
   tca_host u_host (.clk(clk), .address(a), .read(r), .write(w), .writedata(d),
      .byteenable(be), .readdata(q), .waitrequest(wq), .timed_out(to));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic acc(input logic rd, input logic [4:0] ad, input logic [31:0] dd);
      u_host.xfer(rd, ad, dd, v);
      if (to === 1'b1) begin
         n_fail++;
         end_of_test();
      end
   endtask
   task automatic rchk(input logic [4:0] ad, input logic [31:0] e);
      acc(1'b1, ad, 32'h0000_0000);
      chk(v, e);
   endtask
   task automatic wcfg(input logic [7:0] c);
      cfg = c & 8'hF3;
      acc(1'b0, 5'h04, {24'h0, c});
      repeat (3) @(posedge clk);
   endtask
   // wait for the power level, bounded
   task automatic wpwr(input logic lv);
      n = 0;
      while (pwr !== lv && n < 900) begin
         @(posedge clk);
         n++;
      end
      if (n >= 900) begin
         n_fail++;
         end_of_test();
      end
   endtask
   task automatic shot(input logic [9:0] c);
      code <= c;
      acc(1'b0, 5'h04, {24'h0, cfg | 8'h04});
      wpwr(1'b1);
      wpwr(1'b0);
      repeat (3) @(posedge clk);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rchk(5'h04, 32'h0000_0040);
      rchk(5'h08, 32'h0000_007F);
      rchk(5'h0C, 32'h0000_0080);
      rchk(5'h00, 32'h0000_0000);
      chk({31'h0, aoen}, 32'h1);
      $display("test reset values done");
      wcfg(8'h80);
      rchk(5'h04, 32'h0000_0080);
      chk({31'h0, filt}, 32'h0);
      shot(10'h064);
      rchk(5'h00, 32'h0000_0064);
      rchk(5'h04, 32'h0000_0080);
      gap = 0;
      repeat (700) begin
         @(posedge clk);
         gap += int'(pwr);
      end
      chk(gap, 0);
      $display("test one-shot in power-down done");
      code <= 10'h3E0;
      wcfg(8'h40);
      wpwr(1'b1);
      chk({31'h0, (n >= IVL - 5 && n <= IVL + 4)}, 32'h1);
      wpwr(1'b0);
      wpwr(1'b1);
      chk({31'h0, (n >= IVL - 300 && n <= IVL + 4)}, 32'h1);
      wpwr(1'b0);
      wcfg(8'h80);
      rchk(5'h00, 32'h0000_03E0);
      chk(32'((int'(v[8:0]) - 512) / 4), 32'hFFFF_FFF8);
      $display("test automatic mode done");
      acc(1'b0, 5'h08, 32'h0000_0010);
      acc(1'b0, 5'h10, 32'h0000_00FF);
      acc(1'b0, 5'h14, 32'h0000_0008);
      rchk(5'h0C, 32'h0000_0008);
      rchk(5'h10, 32'h0000_0003);
      acc(1'b0, 5'h10, 32'h0000_00FE);
      rchk(5'h14, 32'h0000_0010);
      chk(q2, 32'h0000_0000);
      acc(1'b0, 5'h00, 32'h0000_0155);
      rchk(5'h00, 32'h0000_03E0);
      rchk(5'h18, 32'h0000_0000);
      $display("test pointer and map done");
      shot(10'h3E0);
      chk({31'h0, aoen}, 32'h1);
      shot(10'h0A0);
      chk({31'h0, aoen}, 32'h0);
      chk({31'h0, aoen2}, 32'h1);
      wcfg(8'h90);
      chk({31'h0, aoen}, 32'h1);
      wcfg(8'h80);
      chk({31'h0, aoen}, 32'h0);
      wcfg(8'h88);
      chk({31'h0, aoen}, 32'h1);
      rchk(5'h04, 32'h0000_0080);
      shot(10'h0A0);
      chk({31'h0, aoen}, 32'h0);
      shot(10'h010);
      chk({31'h0, aoen}, 32'h1);
      wcfg(8'hA0);
      shot(10'h0A0);
      chk({31'h0, aoen}, 32'h1);
      wcfg(8'h80);
      chk({31'h0, aoen}, 32'h1);
      $display("test indicator done");
      end_of_test();
   end
endmodule
